// >>> spfc_pkg.sv
package spfc_pkg;

  // frame geometry
  localparam int FRAME_BITS     = 24;
  localparam int MAX_FRAME_BITS = 28;
  localparam int CRC_BITS       = 8;
  localparam int POS_MAX_BITS   = 18;
  localparam int POS_MIN_BITS   = 8;
  localparam int POS_FIT_BITS   = 14;
  localparam int CMD_RW_BIT     = 22;
  localparam int CMD_DATA_LSB   = 8;
  localparam int RSP_WARN_BIT   = 23;
  localparam int RSP_ERR_BIT    = 22;
  localparam int CNT_W          = 5;

  // addresses and mode encodings
  localparam logic [7:0] POS_ADDR        = 8'h3F;
  localparam logic       PSEL_SPI        = 1'b0;
  localparam logic       VARIANT_HIGH_24A = 1'b0;
  localparam logic       VARIANT_LOW_24A  = 1'b1;

  // crc defaults, arbitrary until the full polynomial is known
  localparam logic [7:0] CRC_POLY_DEF = 8'h07;
  localparam logic [7:0] CRC_INIT_DEF = 8'h00;

  // decoded command from the controller
  typedef struct packed {
    logic       rd;
    logic [7:0] addr_data;
  } spfc_cmd_type;

  // answer content supplied by the core
  typedef struct packed {
    logic        warn;
    logic        err;
    logic [7:0]  reg_byte;
    logic [17:0] pos;
    logic [4:0]  res_bits;
  } spfc_rsp_type;

endpackage

// >>> spfc_crc8.sv
`timescale 1ns/1ps
// serial-free crc8 over a 24-bit word, msb first
module spfc_crc8
  import spfc_pkg::*;
#(
  parameter logic [7:0] POLY = spfc_pkg::CRC_POLY_DEF,
  parameter logic [7:0] INIT = spfc_pkg::CRC_INIT_DEF
)
(
  // data
  input  wire logic [23:0] i_data,
  input  wire logic [4:0]  i_len,
  // result
  output logic [7:0]       o_crc
);

  // bits at or above len are skipped so short words sit at the bottom
  always_comb
  begin
    logic [7:0] c;
    logic       fb;
    c = INIT;
    fb = 1'b0;
    for (int k = 23; k >= 0; k--)
    begin
      if (k < int'(i_len))
      begin
        fb = c[7] ^ i_data[k];
        c = {c[6:0], 1'b0} ^ (fb ? POLY : 8'h00);
      end
    end
    o_crc = c;
  end

endmodule

// >>> spfc_core.sv
`timescale 1ns/1ps
// What this block does
// - frame active only with family pin 1, psel 0, variant high 0 and variant low 1.
// - register answer: warn, error, zeros, register byte, crc.
// - positions 8..14 bits left-aligned from bit 21, zero padded, crc last.
// - positions 15..18 bits lengthen frame one bit each, up to 28 bits.
// - 24-bit frames compute crc over the 16 non-crc bits.
// - longer frames zero-pad data to 24 bits before crc.
// - clock idles low; sample on falling edge, shift on rising edge.
// - read to address 0x3F returns the absolute position.
module spfc_core
  import spfc_pkg::*;
#(
  parameter logic [7:0] CRC_POLY = spfc_pkg::CRC_POLY_DEF,
  parameter logic [7:0] CRC_INIT = spfc_pkg::CRC_INIT_DEF
)
(
  // clock and reset
  input  wire logic                  i_clk,
  input  wire logic                  i_rst,
  // serial pins
  input  wire logic                  i_cs_n,
  input  wire logic                  i_sck,
  input  wire logic                  i_mosi,
  input  wire logic                  i_interface_family_pin,
  output logic                       o_miso,
  output logic                       o_miso_oe_n,
  // configuration
  input  wire logic                  i_psel,
  input  wire logic                  i_frame_variant_high,
  input  wire logic                  i_frame_variant_low,
  // answer content
  input  wire spfc_pkg::spfc_rsp_type i_rsp,
  // decoded command
  output spfc_pkg::spfc_cmd_type     o_cmd,
  output logic                       o_cmd_valid,
  output logic                       o_crc_err
);
  import spfc_pkg::*;

  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_SHIFT = 2'b01,
    ST_DONE  = 2'b10,
    ST_TAIL  = 2'b11
  } spfc_state_type;

  // pin synchronisers
  logic [1:0] cs_sync_ff;
  logic [1:0] sck_sync_ff;
  logic [1:0] mosi_sync_ff;
  logic [1:0] fam_sync_ff;
  logic       sck_prev_ff;

  always_ff @(posedge i_clk)
  begin
    cs_sync_ff   <= {cs_sync_ff[0], i_cs_n};
    sck_sync_ff  <= {sck_sync_ff[0], i_sck};
    mosi_sync_ff <= {mosi_sync_ff[0], i_mosi};
    fam_sync_ff  <= {fam_sync_ff[0], i_interface_family_pin};
    sck_prev_ff  <= sck_sync_ff[1];
  end

  // edge decode on the second stage only
  wire sck_rise = sck_sync_ff[1] & ~sck_prev_ff;
  wire sck_fall = ~sck_sync_ff[1] & sck_prev_ff;
  wire cs_act   = ~cs_sync_ff[1];
  // the family pin is a pad, the variant bits come from configuration on this clock
  wire fam_ok   = fam_sync_ff[1];
  wire psel_ok  = (i_psel == PSEL_SPI);
  wire var_ok   = (i_frame_variant_high == VARIANT_HIGH_24A)
                & (i_frame_variant_low == VARIANT_LOW_24A);
  // a frame in another mode is ignored while the mode is off; if the mode turns valid with cs still low, the engine starts mid-frame
  wire mode_ok  = fam_ok & psel_ok & var_ok;

  spfc_state_type              state_ff;
  logic [CNT_W-1:0]            cnt_ff;
  logic [FRAME_BITS-1:0]       rx_ff;
  logic [MAX_FRAME_BITS-1:0]   tx_ff;
  logic                        pos_sel_ff;
  logic                        miso_ff;
  logic                        oe_n_ff;
  spfc_cmd_type                cmd_ff;
  logic                        cmd_valid_ff;
  logic                        crc_err_ff;

  // answer assembly: position read after a read to 0x3F
  wire [4:0] res      = (i_rsp.res_bits < 5'(POS_MIN_BITS)) ? 5'(POS_MIN_BITS) :
                        (i_rsp.res_bits > 5'(POS_MAX_BITS)) ? 5'(POS_MAX_BITS) : i_rsp.res_bits;
  wire [4:0] extra    = (res > 5'(POS_FIT_BITS)) ? 5'(res - 5'(POS_FIT_BITS)) : 5'h0_0;
  wire [4:0] dlen     = 5'(FRAME_BITS - CRC_BITS) + extra;
  wire [17:0] pos_al  = i_rsp.pos << (5'(POS_MAX_BITS) - res);
  // position left aligned under the flags, zeros behind, up to 20 data bits
  wire [19:0] pos_dat = {i_rsp.warn, i_rsp.err, pos_al};
  wire [15:0] reg_dat = {i_rsp.warn, i_rsp.err, 6'h00, i_rsp.reg_byte};
  wire [23:0] crc_in_pos = (extra == 5'h0_0) ? {8'h00, pos_dat[19:4]}
                                             : {pos_dat, 4'h0};
  wire [23:0] crc_in  = pos_sel_ff ? crc_in_pos : {8'h00, reg_dat};
  wire [4:0]  crc_len = (pos_sel_ff && extra != 5'h0_0) ? 5'd24 : 5'd16;
  wire [7:0]  tx_crc;
  // short frames place data at the top; unused low bits of a 28-bit shifter stay zero
  wire [19:0] dat_top = pos_sel_ff ? pos_dat : {reg_dat, 4'h0};
  wire [4:0]  dlen_eff = pos_sel_ff ? dlen : 5'd16;
  // crc sits right under the data, so each extra payload bit moves it down by one
  wire [27:0] tx_load = {dat_top, 8'h00} | ({20'h0_0000, tx_crc} << (5'd20 - dlen_eff));
  wire [27:0] tx_word = tx_load & ~(28'h000_0000 | ({28{1'b1}} >> (dlen_eff + 5'd8)));

  spfc_crc8 #(
    .POLY (CRC_POLY),
    .INIT (CRC_INIT)
  ) u_crc (
    .i_data (crc_in),
    .i_len  (crc_len),
    .o_crc  (tx_crc)
  );

  // check of the received command crc over its 16 data bits
  wire [7:0] rx_crc;
  spfc_crc8 #(
    .POLY (CRC_POLY),
    .INIT (CRC_INIT)
  ) u_rx_crc (
    .i_data ({8'h00, rx_ff[23:8]}),
    .i_len  (5'd16),
    .o_crc  (rx_crc)
  );

  // a corrupted command only raises the error flag; it never steers the next answer
  wire rx_ok   = (rx_crc == rx_ff[7:0]);
  wire pos_req = rx_ff[CMD_RW_BIT] & (rx_ff[CMD_DATA_LSB +: 8] == POS_ADDR);

  // frame engine: shift out on rising sck, capture on falling sck
  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      state_ff     <= ST_IDLE;
      cnt_ff       <= 5'h0_0;
      rx_ff        <= 24'h00_0000;
      tx_ff        <= 28'h000_0000;
      pos_sel_ff   <= 1'b0;
      miso_ff      <= 1'b0;
      oe_n_ff      <= 1'b1;
      cmd_ff       <= '0;
      cmd_valid_ff <= 1'b0;
      crc_err_ff   <= 1'b0;
    end
    else
    begin
      cmd_valid_ff <= 1'b0;
      case (state_ff)
        ST_IDLE:
        begin
          oe_n_ff <= 1'b1;
          cnt_ff  <= 5'h0_0;
          if (cs_act && mode_ok)
          begin
            // previous command decides the answer of this frame
            tx_ff     <= tx_word;
            state_ff  <= ST_SHIFT;
          end
        end
        ST_SHIFT:
        begin
          oe_n_ff <= 1'b0;
          if (!cs_act)
            state_ff <= ST_IDLE;
          else if (sck_rise)
          begin
            miso_ff <= tx_ff[MAX_FRAME_BITS-1];
            tx_ff   <= {tx_ff[MAX_FRAME_BITS-2:0], 1'b0};
          end
          else if (sck_fall)
          begin
            rx_ff  <= {rx_ff[FRAME_BITS-2:0], mosi_sync_ff[1]};
            cnt_ff <= cnt_ff + 5'h0_1;
            if (cnt_ff == 5'(FRAME_BITS - 1))
              state_ff <= ST_DONE;
          end
        end
        ST_DONE:
        begin
          // decode once: staying here would repeat the valid pulse until deselect
          cmd_valid_ff <= rx_ok;
          crc_err_ff   <= ~rx_ok;
          if (rx_ok)
          begin
            cmd_ff.rd        <= rx_ff[CMD_RW_BIT];
            cmd_ff.addr_data <= rx_ff[CMD_DATA_LSB +: 8];
            pos_sel_ff       <= pos_req;
          end
          if (!cs_act)
            state_ff <= ST_IDLE;
          else
          begin
            state_ff <= ST_TAIL;
            if (sck_rise)
            begin
              miso_ff <= tx_ff[MAX_FRAME_BITS-1];
              tx_ff   <= {tx_ff[MAX_FRAME_BITS-2:0], 1'b0};
            end
          end
        end
        ST_TAIL:
        begin
          // long position answers run past bit 24; mosi is ignored from here on
          if (!cs_act)
            state_ff <= ST_IDLE;
          else if (sck_rise)
          begin
            miso_ff <= tx_ff[MAX_FRAME_BITS-1];
            tx_ff   <= {tx_ff[MAX_FRAME_BITS-2:0], 1'b0};
          end
        end
        default: state_ff <= ST_IDLE;
      endcase
    end
  end

  assign o_miso      = miso_ff;
  assign o_miso_oe_n = oe_n_ff;
  assign o_cmd       = cmd_ff;
  assign o_cmd_valid = cmd_valid_ff;
  assign o_crc_err   = crc_err_ff;

endmodule

// >>> spfc_core_asserts.sv
`timescale 1ns/1ps
// watches the serial pins and the decoded command of the frame core
module spfc_core_asserts
(
  // pins and configuration
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_cs_n,
  input wire logic i_sck,
  input wire logic i_interface_family_pin,
  input wire logic i_psel,
  input wire logic i_frame_variant_high,
  input wire logic i_frame_variant_low,
  // design outputs
  input wire logic o_miso,
  input wire logic o_miso_oe_n,
  input wire logic o_cmd_valid,
  input wire logic o_crc_err
);
  // frame variant selected; latencies below allow for the 2-ff pin synchronisers
  wire sel = !i_psel && !i_frame_variant_high && i_frame_variant_low && i_interface_family_pin;
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_rst);
  off_no_cmd_a: assert property (!sel [*4] |-> !o_cmd_valid) else $error("command while unselected");
  off_no_drive_a: assert property ($fell(o_miso_oe_n) |-> sel && !$past(i_cs_n))
    else $error("miso driven while unselected");
  cs_release_a: assert property (i_cs_n [*5] |-> o_miso_oe_n) else $error("miso held after deselect");
  valid_pulse_a: assert property (o_cmd_valid |=> !o_cmd_valid) else $error("valid longer than one cycle");
  valid_in_frame_a: assert property (o_cmd_valid |-> !$past(i_cs_n, 2)) else $error("valid outside frame");
  miso_on_rise_a: assert property ($changed(o_miso) && !o_miso_oe_n && $past(!o_miso_oe_n)
    |-> $past(i_sck, 2)) else $error("miso moved off a clock rise");
  crc_err_frame_a: assert property ($changed(o_crc_err) |-> !$past(i_cs_n, 2)) else $error("crc flag moved");
  bad_crc_drop_a: assert property ($rose(o_crc_err) |-> !o_cmd_valid) else $error("bad frame accepted");
  cover property (o_cmd_valid);
  cover property ($rose(o_crc_err));
  cover property ($fell(o_miso_oe_n));
endmodule

bind spfc_core spfc_core_asserts u_chk (.i_clk, .i_rst, .i_cs_n, .i_sck, .i_interface_family_pin, .i_psel,
  .i_frame_variant_high, .i_frame_variant_low, .o_miso, .o_miso_oe_n, .o_cmd_valid, .o_crc_err);

// >>> spfc_ctl_model.sv
`timescale 1ns/1ps
// serial controller; its clock runs only inside frames
module spfc_ctl_model
(
  // serial pins
  output logic o_cs_n,
  output logic o_sck,
  output logic o_mosi,
  input wire logic i_miso
);
  // idle: deselected, clock parked low
  initial
  begin
    o_cs_n = 1'b1;
    o_sck = 1'b0;
    o_mosi = 1'b0;
  end
  // one frame msb first; clocks past 24 shift zeros
  task automatic xfer(input logic [23:0] i_tx, input int i_n, output logic [27:0] o_rx);
    o_rx = '0;
    o_cs_n = 1'b0;
    #400;
    for (int k = 0; k < i_n; k++)
    begin
      o_sck = 1'b1;
      o_mosi = (k < 24) ? i_tx[23-k] : 1'b0;
      #200;
      o_sck = 1'b0;
      o_rx = {o_rx[26:0], i_miso};
      #200;
    end
    o_cs_n = 1'b1;
    o_mosi = ~o_mosi; // released line must not look held
    #400;
  endtask
endmodule

// >>> spfc_24bit_parallel_crc_frame_test.sv
`timescale 1ns/1ps
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin err_total++; $display("[ERR] %0t mismatch", $time); end end
module spfc_24bit_parallel_crc_frame_test;
  import spfc_pkg::*;
  logic i_clk, i_rst, i_cs_n, i_sck, i_mosi, o_miso, o_miso_oe_n, o_cmd_valid, o_crc_err, oe_seen;
  logic i_interface_family_pin, i_psel, i_frame_variant_high, i_frame_variant_low;
  spfc_rsp_type i_rsp;
  spfc_cmd_type o_cmd, got;
  logic [27:0] rx;
  int err_total, total_checks, vcnt;
  int rt[6] = '{8, 12, 14, 15, 16, 18};
  logic [3:0] bc[4] = '{4'hB, 4'h7, 4'h1, 4'h2};
  wire miso_w = o_miso_oe_n ? ~o_miso : o_miso;
  spfc_core dut (.i_clk, .i_rst, .i_cs_n, .i_sck, .i_mosi, .i_interface_family_pin, .o_miso, .o_miso_oe_n,
    .i_psel, .i_frame_variant_high, .i_frame_variant_low, .i_rsp, .o_cmd, .o_cmd_valid, .o_crc_err);
  spfc_ctl_model ctl (.o_cs_n(i_cs_n), .o_sck(i_sck), .o_mosi(i_mosi), .i_miso(miso_w));
  initial
  begin
    i_clk = 1'b0;
    forever #25 i_clk = ~i_clk;
  end
  // pulses are caught mid-cycle, away from the edge that launches them
  always @(negedge i_clk)
  begin
    if (o_cmd_valid === 1'b1)
    begin
      vcnt++;
      got = o_cmd;
    end
    if (o_miso_oe_n === 1'b0)
      oe_seen = 1'b1;
  end
  function automatic logic [7:0] crc(input logic [23:0] d, input int n);
    logic [7:0] c;
    c = CRC_INIT_DEF;
    for (int i = n - 1; i >= 0; i--) c = {c[6:0], 1'b0} ^ ((c[7] ^ d[i]) ? CRC_POLY_DEF : 8'h00);
    return c;
  endfunction
  task automatic fr(input logic rd, input logic [7:0] b, input logic [7:0] bad, input int n);
    logic [15:0] w;
    w = {1'b0, rd, 6'h00, b};
    // frame edges land just after a clock edge, like every other input
    @(posedge i_clk);
    #1 ctl.xfer({w, crc(24'(w), 16) ^ bad}, n, rx);
  endtask
  // expected answer: flags and payload left aligned, crc last
  task automatic chka(input logic [19:0] d, input int res);
    int sh;
    logic [23:0] wd;
    sh = (res <= 14) ? 14 - res : 0;
    wd = (res <= 14) ? 24'(d) << sh : 24'(d) << (22 - res);
    `CHK(rx, (28'(d) << (sh + 8)) | 28'(crc(wd, (res <= 14) ? 16 : 24)))
  endtask
  task automatic cfg(input logic [3:0] c);
    @(posedge i_clk);
    #1 {i_psel, i_frame_variant_high, i_frame_variant_low, i_interface_family_pin} = c;
    oe_seen = 1'b0;
    repeat (5) @(posedge i_clk);
  endtask
  task results;
    if (err_total == 0 && total_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  initial
  begin
    #1_000_000;
    err_total++;
    results();
  end
  initial
  begin
    i_rst = 1'b1;
    {i_psel, i_frame_variant_high, i_frame_variant_low, i_interface_family_pin} = 4'h3;
    i_rsp = '{warn: 1'b1, err: 1'b0, reg_byte: 8'hA5, pos: 18'h2_ABCD, res_bits: 5'h0C};
    {err_total, total_checks, vcnt, oe_seen} = '0;
    repeat (10) @(posedge i_clk);
    #1 i_rst = 1'b0;
    repeat (4) @(posedge i_clk);
    fr(1'b0, 8'h5A, 8'h00, 24);
    `CHK(got, {1'b0, 8'h5A})
    fr(1'b1, 8'h12, 8'h00, 24);
    `CHK(got.rd, 1'b1)
    fr(1'b1, POS_ADDR, 8'h00, 24);
    chka(20'({2'b10, 6'h00, 8'hA5}), 14);
    foreach (rt[k])
    begin
      @(posedge i_clk);
      #1 i_rsp.res_bits = 5'(rt[k]);
      fr(1'b1, POS_ADDR, 8'h00, (rt[k] <= 14) ? 24 : rt[k] + 10);
      chka((20'(2'b10) << rt[k]) | 20'(i_rsp.pos & ((18'h1 << rt[k]) - 18'h1)), rt[k]);
    end
    fr(1'b0, 8'h77, 8'h01, 24);
    `CHK(o_crc_err, 1'b1)
    `CHK(o_cmd, {1'b1, POS_ADDR})
    `CHK(vcnt, 9)
    foreach (bc[k])
    begin
      cfg(bc[k]);
      fr(1'b0, 8'h33, 8'h00, 24);
      `CHK(oe_seen, 1'b0)
    end
    cfg(4'h3);
    fr(1'b0, 8'h5A, 8'h00, 24);
    `CHK(o_crc_err, 1'b0)
    `CHK(vcnt, 10)
    `CHK(oe_seen, 1'b1)
    results();
  end
endmodule
